/* File: sim/spc_surface_model.sv */
// Purpose: control surface keys, joystick and audio source of one channel
// Assumes: every task is entered just after a rising clock edge
// Notes: data lines show inverted values once their strobe drops
`timescale 1ns/100ps
`default_nettype none
module spc_surface_model #(
  parameter int SW = 24
) (
  // Clock
  input  wire logic            clk,
  // Keys and joystick
  output logic                 followKey,
  output logic                 selectThis,
  output logic                 selectOther,
  output logic                 joyValid,
  output logic [7:0]           joyX,
  output logic [7:0]           joyY,
  // Audio source
  output logic                 sampleValid,
  output logic signed [SW-1:0] sampleL,
  output logic signed [SW-1:0] sampleR
);
  initial begin
    {followKey, selectThis, selectOther, joyValid, sampleValid} = 5'h0;
    {joyX, joyY} = 16'h0000;
    sampleL = '0;
    sampleR = '0;
  end

  // Key codes: 0 follow, 1 this channel's select, 2 another channel's select
  task automatic pressKey(input int k);
    followKey   <= (k == 0);
    selectThis  <= (k == 1);
    selectOther <= (k == 2);
    @(posedge clk);
    {followKey, selectThis, selectOther} <= 3'h0;
    @(posedge clk);
  endtask

  task automatic moveJoy(input logic [7:0] x, input logic [7:0] y);
    joyValid <= 1'b1;
    joyX     <= x;
    joyY     <= y;
    @(posedge clk);
    joyValid <= 1'b0;
    joyX     <= ~x;
    joyY     <= ~y;
    @(posedge clk);
  endtask

  // Returns at the boundary edge so the caller can look at the answer
  task automatic playSample(input logic [SW-1:0] l, input logic [SW-1:0] r);
    sampleValid <= 1'b1;
    sampleL     <= l;
    sampleR     <= r;
    @(posedge clk);
    sampleValid <= 1'b0;
    sampleL     <= ~l;
    sampleR     <= ~r;
  endtask
endmodule // spc_surface_model
`default_nettype wire

/* File: sim/spc_surround_pan_tb_top.sv */
// Purpose: self-checking bench of the channel pan section
// Assumes: AHB-Lite slave with zero wait states, shadow set copied at each boundary
// Notes: each new pan setting is checked on the second sample after it is written, register fields by read-back
`timescale 1ns/100ps
`include "spc_consts.svh"
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nMismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module spc_surround_pan_tb_top;
  logic             clk, rst, hsel, hwrite;
  logic [7:0]       haddr;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      hwdata, hrdata, rd;
  logic             hreadyout, hresp, joyOwned, busValid;
  logic [7:0][23:0] busOut, got;
  wire logic        followKey, selectThis, selectOther, joyValid, sampleValid;
  wire logic [7:0]  joyX, joyY;
  wire logic signed [23:0] sampleL, sampleR;
  int               nMismatch, numChecks;
  logic [7:0]       posTab [3] = '{8'hE2, 8'h00, 8'h1E};
  logic [23:0]      oddTab [3] = '{24'h10_0000, 24'h08_0000, 24'h00_0000};
  logic [23:0]      evnTab [3] = '{24'h00_0000, 24'h08_0000, 24'h10_0000};
  localparam logic [5:0] MODES = 6'h0D;

  spc_surround_pan u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .followKey(followKey),
    .selectThis(selectThis), .selectOther(selectOther), .joyValid(joyValid), .joyX(joyX),
    .joyY(joyY), .joyOwned(joyOwned), .sampleValid(sampleValid), .sampleL(sampleL),
    .sampleR(sampleR), .busValid(busValid), .busOut(busOut));
  spc_surface_model u_surf (.clk(clk), .followKey(followKey), .selectThis(selectThis),
    .selectOther(selectOther), .joyValid(joyValid), .joyX(joyX), .joyY(joyY),
    .sampleValid(sampleValid), .sampleL(sampleL), .sampleR(sampleR));

  always #2 clk = ~clk;

  task automatic printVerdict();
    if (nMismatch == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      nMismatch++;
      printVerdict();
    end
  endtask

  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
  endtask

  task automatic regChk(input string nm, input logic [7:0] a, input logic [31:0] e);
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    waitRdy();
    htrans <= 2'h0;
    waitRdy();
    rd = hrdata;
    `CHK(nm, e, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic sample(input logic [23:0] l, input logic [23:0] r);
    u_surf.playSample(l, r);
    #1;
    `CHK("busValid", 1'b1, busValid)
    got = busOut;
    @(posedge clk);
  endtask

  initial begin
    #100000;
    nMismatch++;
    printVerdict();
  end

  initial begin
    {clk, rst, hsel, hwrite, htrans, haddr, hwdata} = {3'b011, 1'b0, 2'h0, 8'h00, 32'h0};
    hsize = 3'h2;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    regChk("ctrlRst", `SPC_A_CTRL, 32'h0000_0001);
    regChk("panRst", `SPC_A_PAN, 32'h0064_0000);
    regChk("mixRst", `SPC_A_MIX, 32'h0312_0000);
    regChk("maskRst", `SPC_A_MASK, 32'h0000_00FF);
    busWrite(8'h1C, 32'hFFFF_FFFF);
    regChk("unmapped", 8'h1C, 32'h0000_0000);
    busWrite(`SPC_A_CTRL, 32'h0000_01FF);
    regChk("ctrlAll", `SPC_A_CTRL, 32'h0000_01FF);
    busWrite(`SPC_A_PAN, 32'h00FF_2828);
    regChk("panClamp", `SPC_A_PAN, 32'h00C8_1E1E);
    busWrite(`SPC_A_SURR, 32'hFF50_2880);
    regChk("surrClamp", `SPC_A_SURR, 32'hFF3C_1E64);
    busWrite(`SPC_A_MIX, 32'h071F_03FF);
    regChk("mixClamp", `SPC_A_MIX, 32'h0512_032A);
    for (int i = 0; i < 3; i++) begin
      busWrite(`SPC_A_CMD, 32'h0000_0001);
      regChk("bleedMode", `SPC_A_STAT, {30'h0, MODES[2*i +: 2]});
    end
    // Pan off, mono: the first boundary still plays the all-zero reset set
    busWrite(`SPC_A_CTRL, 32'h0000_0000);
    sample(24'h10_0000, 24'h20_0000);
    `CHK("firstSample", 192'h0, got)
    sample(24'h10_0000, 24'h20_0000);
    `CHK("monoBypass", {8{24'h10_0000}}, got)
    busWrite(`SPC_A_CTRL, 32'h0000_0002);
    busWrite(`SPC_A_MASK, 32'h0000_000F);
    sample(24'h10_0000, 24'h20_0000);
    `CHK("oldSetHeld", {8{24'h10_0000}}, got)
    sample(24'h10_0000, 24'h20_0000);
    `CHK("stereoBypass", {96'h0, {2{24'h20_0000, 24'h10_0000}}}, got)
    busWrite(`SPC_A_CTRL, 32'h0000_0001);
    busWrite(`SPC_A_MASK, 32'h0000_00FF);
    for (int i = 0; i < 3; i++) begin
      busWrite(`SPC_A_PAN, {16'h0064, 8'h00, posTab[i]});
      sample(24'h10_0000, 24'h20_0000);
      sample(24'h10_0000, 24'h20_0000);
      `CHK("panOdd", oddTab[i], got[0])
      `CHK("panEven", evnTab[i], got[1])
      `CHK("panOthers", 144'h0, got[7:2])
    end
    // Joystick ownership follows the follow-then-select sequence
    busWrite(`SPC_A_SURR, 32'h0000_0000);
    u_surf.pressKey(1);
    `CHK("ownNoFollow", 1'b0, joyOwned)
    u_surf.pressKey(0);
    u_surf.pressKey(1);
    `CHK("owned", 1'b1, joyOwned)
    u_surf.moveJoy(8'hF6, 8'h50);
    regChk("joyPan", `SPC_A_SURR, 32'h003C_F600);
    u_surf.pressKey(2);
    `CHK("released", 1'b0, joyOwned)
    u_surf.moveJoy(8'h05, 8'h05);
    regChk("joyIgnored", `SPC_A_SURR, 32'h003C_F600);
    // Surround 5.1, front panned full right, unity low-frequency feed
    busWrite(`SPC_A_CTRL, 32'h0000_0141);
    busWrite(`SPC_A_SURR, 32'h0000_1E00);
    busWrite(`SPC_A_MIX, 32'h0312_0100);
    sample(24'h10_0000, 24'h20_0000);
    sample(24'h10_0000, 24'h20_0000);
    `CHK("surround", {96'h0, 24'h10_0000, 24'h00_0000, 24'h10_0000, 24'h00_0000}, got)
    busWrite(`SPC_A_CTRL, 32'h0000_0041);
    sample(24'h10_0000, 24'h20_0000);
    sample(24'h10_0000, 24'h20_0000);
    `CHK("lfeOff", {144'h0, 24'h10_0000, 24'h00_0000}, got)
    printVerdict();
  end
endmodule // spc_surround_pan_tb_top
`default_nettype wire

/* File: verilog/spc_consts.svh */
// Purpose: constants of the channel pan section
// Assumes: AHB-Lite word registers, 24-bit samples
// Notes: gains are unsigned, unity is 256
// Operation
// - Pan section off: every assigned bus gets the channel signal unchanged
// - Mono pan position in 1 degree steps, -30 left to +30 right
// - Stereo input selector balance or direction, plus enable for the selected one
// - Balance left attenuates right to mute, left stays full; mirror for right
// - Input direction shifts stereo input in 1 degree steps, -30 to +30
// - Stereo output image positioned on odd/even buses, -30 to +30 degrees
// - Width spreads stereo from 0 percent mono to 200 percent wide
// - Width audible only when left and right differ or are offset
// - Width control and switch exist only if width is configured
// - Six surround formats; controls not in the format are blanked
// - Centre use 0 to 100 percent with its own enable
// - Front pan in 1 degree steps, centre share set by centre percent
// - Front/back pan in 60 increments, separate left/right surround pan
// - Low-frequency feed from mute to +10 dB with its own switch
// - No filtering on the low-frequency feed
// - Bleed mode off, front or all; each key press steps cyclically
// - Bleed amount only 1-5, 10-50 by 5, 60-100 by 10 percent
// - Bleed 100 percent, no centre: full left mutes right
// - Bleed 50 percent feeds half into opposite channel, panned one unchanged
// - Bleed 1 percent feeds both equally, pan has no effect
// - Surround panner only on mono channel types
// - Follow key then select key assigns joystick; other select reassigns it
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_A_CTRL 8'h00
`define SPC_A_PAN 8'h04
`define SPC_A_SURR 8'h08
`define SPC_A_MIX 8'h0C
`define SPC_A_MASK 8'h10
`define SPC_A_CMD 8'h14
`define SPC_A_STAT 8'h18
`define SPC_B0 7:0
`define SPC_B1 15:8
`define SPC_B2 23:16
`define SPC_B3 31:24
`define SPC_LFE_F 9:0
`define SPC_BLEED_F 20:16
`define SPC_FMT_F 26:24
`define SPC_C_PANEN 0
`define SPC_C_STEREO 1
`define SPC_C_WCFG 2
`define SPC_C_INSEL 3
`define SPC_C_INEN 4
`define SPC_C_WEN 5
`define SPC_C_SURR 6
`define SPC_C_CEN 7
`define SPC_C_LFEEN 8
`define SPC_CTRL_RST 9'h001
`define SPC_ANG_MAX 8'h1E
`define SPC_FB_MAX 8'h3C
`define SPC_WIDTH_MAX 8'hC8
`define SPC_WIDTH_RST 8'h64
`define SPC_PCT_MAX 8'h64
`define SPC_LFE_MAX 10'h32A
`define SPC_UNITY 10'h100
`define SPC_STEP_MUL 20'h0_1112
`define SPC_PCT_MUL 20'h0_0A3D
`define SPC_BLEED_LAST 5'h12
`define SPC_MASK_RST 8'hFF
`endif

/* File: verilog/spc_pkg.sv */
// Purpose: types of the channel pan section
// Assumes: nothing beyond the constants header
// Notes: bleed mode codes step 00 -> 01 -> 11
package spc_pkg;
  typedef enum logic [1:0] {SPC_BL_OFF = 2'h0, SPC_BL_FRONT = 2'h1, SPC_BL_ALL = 2'h3} spc_bleed_t;
  typedef enum logic [2:0] {SPC_F_LR = 3'h0, SPC_F_LCR = 3'h1, SPC_F_LCRS = 3'h2,
                            SPC_F_51 = 3'h3, SPC_F_EX = 3'h4, SPC_F_71 = 3'h5} spc_format_t;
  typedef struct packed {
    logic        panEn, stereo, widthOn, inEn, inSel, centreEn, lfeEn, surr;
    spc_bleed_t  bleedMode;
    spc_format_t format;
    logic [7:0]  busMask, panPos, inAdj, width, centre, frontPan, fbPos, backPan;
    logic [9:0]  lfeGain;
    logic [4:0]  bleedIdx;
  } spc_params_t;
endpackage

/* File: verilog/spc_surround_pan.sv */
// Purpose: channel pan section, bus slave, gain math, joystick follow
// Assumes: one sample pair per sampleValid pulse, at least two clocks apart
// Notes: bus outputs appear one clock after sampleValid
`timescale 1ns/100ps
`include "spc_consts.svh"
`default_nettype none
module spc_surround_pan
  import spc_pkg::*;
#(
  parameter int SW = 24
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Control surface
  input  wire logic                 followKey,
  input  wire logic                 selectThis,
  input  wire logic                 selectOther,
  input  wire logic                 joyValid,
  input  wire logic [7:0]           joyX,
  input  wire logic [7:0]           joyY,
  output logic                      joyOwned,
  // Audio
  input  wire logic                 sampleValid,
  input  wire logic signed [SW-1:0] sampleL,
  input  wire logic signed [SW-1:0] sampleR,
  output logic                      busValid,
  output logic [7:0][SW-1:0]        busOut
);
  localparam logic [7:0] ANGN = 8'(-`SPC_ANG_MAX);

  function automatic logic [7:0] clampAng(input logic [7:0] v);
    if ($signed(v) > $signed(`SPC_ANG_MAX)) clampAng = `SPC_ANG_MAX;
    else if ($signed(v) < $signed(ANGN)) clampAng = ANGN;
    else clampAng = v;
  endfunction
  function automatic logic [7:0] clampU(input logic [7:0] v, input logic [7:0] m);
    clampU = (v > m) ? m : v;
  endfunction
  // Share toward the right for position 0..60
  function automatic logic [9:0] panR(input logic [7:0] pos);
    logic [27:0] p;
    p = 28'(pos) * 28'(`SPC_STEP_MUL);
    p = p >> 10;
    panR = (p > 28'(`SPC_UNITY)) ? `SPC_UNITY : p[9:0];
  endfunction
  function automatic logic [9:0] posOf(input logic [7:0] ang);
    posOf = panR(8'(ang + `SPC_ANG_MAX));
  endfunction
  // Twice a share, held at unity: balance and stereo image gains
  function automatic logic [9:0] dbl(input logic [9:0] g);
    dbl = (g >= 10'h080) ? `SPC_UNITY : 10'({g, 1'b0});
  endfunction
  function automatic logic [9:0] pctQ(input logic [7:0] pct);
    logic [27:0] p;
    p = 28'(pct) * 28'(`SPC_PCT_MUL);
    pctQ = p[19:10];
  endfunction
  function automatic logic [9:0] mulQ(input logic [9:0] a, input logic [9:0] b);
    logic [19:0] p;
    p = a * b;
    mulQ = p[17:8];
  endfunction
  function automatic logic signed [SW+1:0] scale(input logic signed [SW-1:0] s,
                                                 input logic [9:0] g);
    logic signed [SW+10:0] p;
    p = s * $signed({1'b0, g});
    scale = (SW+2)'(p >>> 8);
  endfunction
  function automatic logic [SW-1:0] sat(input logic signed [SW+1:0] v);
    logic signed [SW+1:0] hi;
    hi = (SW+2)'({1'b0, {(SW-1){1'b1}}});
    if (v > hi) sat = hi[SW-1:0];
    else if (v < -hi - 1) sat = {1'b1, {(SW-1){1'b0}}};
    else sat = v[SW-1:0];
  endfunction
  // Bleed percentage table
  function automatic logic [7:0] bleedPct(input logic [4:0] i);
    if (i < 5'h05) bleedPct = 8'(i) + 8'h01;
    else if (i < 5'h0E) bleedPct = 8'(i - 5'h03) * 8'h05;
    else bleedPct = 8'(i - 5'h08) * 8'h0A;
  endfunction
  // Raise the weaker side toward the stronger one
  function automatic logic [9:0] bleedLo(input logic [9:0] lo, input logic [9:0] hi,
                                         input logic [9:0] keep);
    bleedLo = lo + mulQ(hi - lo, `SPC_UNITY - keep);
  endfunction

  // Bus slave
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic [8:0]  ctrl;
  logic        armed;
  logic [7:0]  panPos, inAdj, width, centre, frontPan, fbPos, backPan, busMask;
  logic [9:0]  lfeGain;
  logic [4:0]  bleedIdx;
  spc_format_t format;
  spc_bleed_t  bleedMode;
  spc_params_t shadow;
  wire spc_params_t live;
  wire         addrPhase = hsel && htrans[1] && hready;
  wire         wrCtrl = wrPend && wrAddr == `SPC_A_CTRL;
  wire         wrPan = wrPend && wrAddr == `SPC_A_PAN;
  wire         wrSurr = wrPend && wrAddr == `SPC_A_SURR;
  wire         wrMix = wrPend && wrAddr == `SPC_A_MIX;
  wire         wrMask = wrPend && wrAddr == `SPC_A_MASK;
  wire         wrStep = wrPend && wrAddr == `SPC_A_CMD && hwdata[0];
  wire         joyTake = joyOwned && joyValid;
  wire [31:0]  rdData =
      haddr == `SPC_A_CTRL ? 32'(ctrl) :
      haddr == `SPC_A_PAN  ? {8'h00, live.width, live.inAdj, live.panPos} :
      haddr == `SPC_A_SURR ? {live.backPan, live.fbPos, live.frontPan, live.centre} :
      haddr == `SPC_A_MIX  ? {5'h00, live.format, 3'h0, live.bleedIdx, 6'h00, live.lfeGain} :
      haddr == `SPC_A_MASK ? 32'(live.busMask) :
      haddr == `SPC_A_STAT ? 32'({armed, joyOwned, live.bleedMode}) : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend <= addrPhase && hwrite;
      wrAddr <= haddr;
      if (addrPhase && !hwrite) hrdata <= rdData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ctrl <= `SPC_CTRL_RST;
    else if (wrCtrl) ctrl <= hwdata[8:0];
  end

  // Live parameter set, clamped to the legal ranges on entry
  assign live.panEn    = ctrl[`SPC_C_PANEN];
  assign live.stereo   = ctrl[`SPC_C_STEREO];
  assign live.widthOn  = ctrl[`SPC_C_WCFG] && ctrl[`SPC_C_WEN];
  assign live.inEn     = ctrl[`SPC_C_INEN];
  assign live.inSel    = ctrl[`SPC_C_INSEL];
  assign live.centreEn = ctrl[`SPC_C_CEN];
  assign live.lfeEn    = ctrl[`SPC_C_LFEEN];
  assign live.surr     = ctrl[`SPC_C_SURR] && !ctrl[`SPC_C_STEREO];
  assign live.bleedMode = bleedMode;
  assign live.format    = format;
  assign live.busMask   = busMask;
  assign live.panPos    = panPos;
  assign live.inAdj     = inAdj;
  assign live.width     = width;
  assign live.centre    = centre;
  assign live.frontPan  = frontPan;
  assign live.fbPos     = fbPos;
  assign live.backPan   = backPan;
  assign live.lfeGain   = lfeGain;
  assign live.bleedIdx  = bleedIdx;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      panPos <= 8'h00;
      inAdj  <= 8'h00;
      width  <= `SPC_WIDTH_RST;
    end else if (wrPan) begin
      panPos <= clampAng(hwdata[`SPC_B0]);
      inAdj  <= clampAng(hwdata[`SPC_B1]);
      width  <= clampU(hwdata[`SPC_B2], `SPC_WIDTH_MAX);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      centre   <= 8'h00;
      frontPan <= 8'h00;
      fbPos    <= 8'h00;
      backPan  <= 8'h00;
    end else if (wrSurr) begin
      centre   <= clampU(hwdata[`SPC_B0], `SPC_PCT_MAX);
      frontPan <= clampAng(hwdata[`SPC_B1]);
      fbPos    <= clampU(hwdata[`SPC_B2], `SPC_FB_MAX);
      backPan  <= clampAng(hwdata[`SPC_B3]);
    end else if (joyTake) begin
      frontPan <= clampAng(joyX);
      fbPos    <= clampU(joyY, `SPC_FB_MAX);
    end
  end

  wire [2:0] fmtIn = (hwdata[`SPC_FMT_F] > 3'(SPC_F_71)) ? 3'(SPC_F_71) : hwdata[`SPC_FMT_F];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfeGain  <= 10'h000;
      bleedIdx <= `SPC_BLEED_LAST;
      format   <= SPC_F_51;
      busMask  <= `SPC_MASK_RST;
    end else begin
      if (wrMix) begin
        lfeGain  <= (hwdata[`SPC_LFE_F] > `SPC_LFE_MAX) ? `SPC_LFE_MAX
                                                        : hwdata[`SPC_LFE_F];
        bleedIdx <= (hwdata[`SPC_BLEED_F] > `SPC_BLEED_LAST) ? `SPC_BLEED_LAST
                                                              : hwdata[`SPC_BLEED_F];
        format   <= spc_format_t'(fmtIn);
      end
      if (wrMask) busMask <= hwdata[`SPC_B0];
    end
  end

  // Bleed mode key steps off, front, all, off
  spc_bleed_t next_bleed;
  always_comb begin
    unique case (live.bleedMode)
      SPC_BL_OFF:   next_bleed = SPC_BL_FRONT;
      SPC_BL_FRONT: next_bleed = SPC_BL_ALL;
      SPC_BL_ALL:   next_bleed = SPC_BL_OFF;
      default:      next_bleed = SPC_BL_OFF;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) bleedMode <= SPC_BL_OFF;
    else if (wrStep) bleedMode <= next_bleed;
  end

  // Joystick follow: arm with the follow key, take with this select key
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed    <= 1'b0;
      joyOwned <= 1'b0;
    end else begin
      armed <= followKey || (armed && !selectThis && !selectOther);
      if (selectOther) joyOwned <= 1'b0;
      else if (armed && selectThis) joyOwned <= 1'b1;
    end
  end

  // Parameter set is taken whole at each sample boundary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) shadow <= '0;
    else if (sampleValid) shadow <= live;
  end

  // Stereo path
  wire [9:0] inR  = posOf(shadow.inAdj);
  wire [9:0] inBl = dbl(`SPC_UNITY - inR);
  wire [9:0] inBr = dbl(inR);
  wire       useIn = shadow.inEn;
  wire [9:0] kL = useIn ? inBl : `SPC_UNITY;
  wire [9:0] kR = useIn ? inBr : `SPC_UNITY;
  wire [9:0] xLR = (useIn && shadow.inSel) ? `SPC_UNITY - inBl : 10'h000;
  wire [9:0] xRL = (useIn && shadow.inSel) ? `SPC_UNITY - inBr : 10'h000;
  wire signed [SW+1:0] stL = scale(sampleL, kL) + scale(sampleR, xRL);
  wire signed [SW+1:0] stR = scale(sampleR, kR) + scale(sampleL, xLR);
  wire [SW-1:0] stLs = sat(stL);
  wire [SW-1:0] stRs = sat(stR);
  wire signed [SW+1:0] mid  = (stL + stR) >>> 1;
  wire signed [SW+1:0] side = (stL - stR) >>> 1;
  wire [9:0] wq = shadow.widthOn ? pctQ(shadow.width) : `SPC_UNITY;
  wire signed [SW+11:0] sideP = side * $signed({1'b0, wq});
  wire signed [SW+1:0] sideW = (SW+2)'(sideP >>> 8);
  wire [SW-1:0] wL = sat(mid + sideW);
  wire [SW-1:0] wR = sat(mid - sideW);
  wire [9:0] imR = posOf(shadow.panPos);
  wire [SW-1:0] oOdd  = sat(scale($signed(wL), dbl(`SPC_UNITY - imR)));
  wire [SW-1:0] oEven = sat(scale($signed(wR), dbl(imR)));
  wire unusedSt = ^{stLs, stRs};

  // Mono pan
  wire [9:0] mR = imR;
  wire [9:0] mL = `SPC_UNITY - imR;

  // Surround gains
  wire [9:0] fR0 = posOf(shadow.frontPan);
  wire [9:0] fL0 = `SPC_UNITY - fR0;
  wire [9:0] cPeak = dbl(fL0 < fR0 ? fL0 : fR0);
  wire       hasC = shadow.format != SPC_F_LR;
  wire [9:0] cg = (hasC && shadow.centreEn) ? mulQ(pctQ(shadow.centre), cPeak) : 10'h000;
  wire [9:0] fL1 = mulQ(fL0, `SPC_UNITY - cg);
  wire [9:0] fR1 = mulQ(fR0, `SPC_UNITY - cg);
  wire [9:0] bq = pctQ(bleedPct(shadow.bleedIdx)) + 10'h001;
  wire [9:0] keep = (bq > `SPC_UNITY) ? `SPC_UNITY : bq;
  wire       dvF = shadow.bleedMode != SPC_BL_OFF;
  wire       dvA = shadow.bleedMode == SPC_BL_ALL;
  wire [9:0] fL2 = (dvF && fL1 < fR1) ? bleedLo(fL1, fR1, keep) : fL1;
  wire [9:0] fR2 = (dvF && fR1 < fL1) ? bleedLo(fR1, fL1, keep) : fR1;
  wire [9:0] bR0 = posOf(shadow.backPan);
  wire [9:0] bL0 = `SPC_UNITY - bR0;
  wire [9:0] bL1 = (dvA && bL0 < bR0) ? bleedLo(bL0, bR0, keep) : bL0;
  wire [9:0] bR1 = (dvA && bR0 < bL0) ? bleedLo(bR0, bL0, keep) : bR0;
  wire [9:0] fbq = panR(shadow.fbPos);
  wire [9:0] frW = `SPC_UNITY - fbq;
  wire       oneS = shadow.format == SPC_F_LCRS;
  wire [9:0] sL = oneS ? fbq : mulQ(bL1, fbq);
  wire [9:0] sR = oneS ? 10'h000 : mulQ(bR1, fbq);
  wire [9:0] sB = mulQ(10'(({1'b0, sL} + {1'b0, sR}) >> 1), `SPC_UNITY);
  wire [9:0] lfe = shadow.lfeEn ? shadow.lfeGain : 10'h000;

  // Buses kept by each format
  logic [7:0] fmtMask;
  always_comb begin
    unique case (shadow.format)
      SPC_F_LR:   fmtMask = 8'h03;
      SPC_F_LCR:  fmtMask = 8'h07;
      SPC_F_LCRS: fmtMask = 8'h17;
      SPC_F_51:   fmtMask = 8'h3F;
      SPC_F_EX:   fmtMask = 8'h7F;
      SPC_F_71:   fmtMask = 8'hFF;
      default:    fmtMask = 8'h03;
    endcase
  end

  logic [7:0][9:0] sg;
  assign sg[0] = mulQ(fL2, frW);
  assign sg[1] = mulQ(fR2, frW);
  assign sg[2] = mulQ(cg, frW);
  assign sg[3] = lfe;
  assign sg[4] = sL;
  assign sg[5] = sR;
  assign sg[6] = (shadow.format == SPC_F_EX) ? sB : sL;
  assign sg[7] = sR;

  // Bus values for this sample
  logic [7:0][SW-1:0] next_busOut;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!shadow.busMask[i])
        next_busOut[i] = '0;
      else if (!shadow.panEn)
        next_busOut[i] = (shadow.stereo && i[0]) ? sampleR : sampleL;
      else if (shadow.stereo)
        next_busOut[i] = (i > 1) ? '0 : (i[0] ? oEven : oOdd);
      else if (shadow.surr)
        next_busOut[i] = fmtMask[i] ? sat(scale(sampleL, sg[i])) : '0;
      else
        next_busOut[i] = (i > 1) ? '0 : sat(scale(sampleL, i[0] ? mR : mL));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busOut   <= '0;
      busValid <= 1'b0;
    end else begin
      busValid <= sampleValid;
      if (sampleValid) busOut <= next_busOut;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  bypass_route_a: assert property (sampleValid && !shadow.panEn && !shadow.stereo
      && shadow.busMask[5] |=> busOut[5] == $past(sampleL))
    else $error("bypass did not pass the sample unchanged");
  pan_range_a: assert property ($signed(live.panPos) <= $signed(`SPC_ANG_MAX)
      && $signed(live.panPos) >= $signed(ANGN))
    else $error("pan position out of range");
  width_range_a: assert property (wrPan |=> live.width <= `SPC_WIDTH_MAX)
    else $error("width above limit");
  fb_range_a: assert property (wrSurr |=> live.fbPos <= `SPC_FB_MAX
      && live.centre <= `SPC_PCT_MAX)
    else $error("front/back or centre out of range");
  bleed_step_a: assert property (wrStep && live.bleedMode == SPC_BL_ALL |=> live.bleedMode == SPC_BL_OFF)
    else $error("bleed mode did not wrap to off");
  bleed_index_a: assert property (live.bleedIdx <= `SPC_BLEED_LAST)
    else $error("bleed index outside table");
  lfe_mute_a: assert property (sampleValid && shadow.panEn && shadow.surr && !shadow.lfeEn
      |=> busOut[3] == '0)
    else $error("low-frequency feed not muted");
  centre_off_a: assert property (sampleValid && shadow.panEn && shadow.surr
      && !shadow.centreEn |=> busOut[2] == '0)
    else $error("centre fed while centre use off");
  stereo_no_surr_a: assert property (sampleValid && shadow.panEn && shadow.stereo
      |=> busOut[2] == '0 && busOut[4] == '0)
    else $error("stereo channel reached surround buses");
  joy_take_a: assert property (armed && selectThis && !selectOther |=> joyOwned)
    else $error("joystick not assigned");
  joy_drop_a: assert property (selectOther |=> !joyOwned)
    else $error("joystick not released");
  shadow_hold_a: assert property (!sampleValid |=> $stable(shadow))
    else $error("parameters changed between samples");

  bypass_c: cover property (sampleValid && !shadow.panEn ##1 busValid);
  surround_c: cover property (sampleValid && shadow.surr && shadow.format == SPC_F_51);
  joystick_c: cover property (joyTake);
  width_c: cover property (sampleValid && shadow.stereo && shadow.widthOn && unusedSt);
endmodule // spc_surround_pan
`default_nettype wire
